/* hw/rbd_cfg.v */
// burst-mode and drive C/D edge-timing slice of a resonant pwm generator, with ahb-lite registers
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "rbd_regs.vh"

module rbd_cfg #(
    parameter PERIOD_W = 16 // width of the switching period count, 5 ns units
) (
    input wire REF_CLK, // core clock, 40 MHz
    input wire RSTN, // async reset, active low
    input wire HSEL, // ahb slave select
    input wire [31:0] HADDR, // ahb address
    input wire [1:0] HTRANS, // ahb transfer type
    input wire HWRITE, // ahb write
    input wire [2:0] HSIZE, // ahb size, word only
    input wire [31:0] HWDATA, // ahb write data
    input wire HREADY, // ahb bus ready
    output wire HREADYOUT, // ahb slave ready, always high
    output wire HRESP, // ahb response, always okay
    output reg [31:0] HRDATA, // ahb read data
    input wire SOFT_START, // soft start in progress, same clock domain
    output reg PRIMARY_DRIVE_C, // drive output c
    output reg PRIMARY_DRIVE_D, // drive output d
    output reg BURST_ACTIVE, // current cycle skipped for burst
    output reg CYCLE_END // one-cycle pulse at each cycle boundary
);

    ////////////////////////////////////////////////////////////////////////////////
    // software-visible registers
    reg [7:0] fmax_hi_q; // eight msbs of minimum period
    reg [3:0] fmax_lo_q; // four lsbs of minimum period
    reg [7:0] burst_q; // burst enable and offset
    reg [7:0] c_fall_lead_time_q; // drive c falling lead
    reg [7:0] d_rise_offset_time_q; // drive d signed rising offset
    reg [PERIOD_W-1:0] period_q; // commanded switching period
    reg run_q; // generator enable

    // working copies, loaded at a cycle boundary or while the generator is stopped
    reg [11:0] min_per_s_q; // minimum period in use
    reg [7:0] burst_s_q; // burst settings in use
    reg [7:0] c_lead_s_q; // c lead in use
    reg [7:0] d_ofs_s_q; // d offset in use
    reg [PERIOD_W-1:0] period_s_q; // period in use

    // ahb data-phase capture
    reg wr_pend_q; // a write data phase is due
    reg [7:0] wr_idx_q; // index of the pending write

    // cycle timer in 5 ns units
    reg [PERIOD_W-1:0] tmr_q; // position inside the current cycle
    reg [PERIOD_W-1:0] tmr_d; // next position
    reg burst_skip_q; // present cycle is a burst skip

    ////////////////////////////////////////////////////////////////////////////////
    // ahb-lite slave: zero wait states, always okay
    // hsize is not decoded: every access is taken as one whole word
    // a read right after a write to the same word still returns the old value,
    // since the write only lands at the end of its data phase
    wire addr_ok = HSEL && HREADY && HTRANS[1]; // nonseq or seq address phase
    wire [7:0] a_idx = HADDR[9:2]; // word index of the access
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;

    // read mux, evaluated in the address phase and flopped for the data phase
    reg [31:0] rd_mux; // value the addressed register shows
    always @* begin
        rd_mux = 32'h00000000; // unmapped words read as zero
        case (a_idx)
            `RBD_IDX_FMAX_HI: rd_mux = {24'h000000, fmax_hi_q};
            `RBD_IDX_FMAX_LO: rd_mux = {24'h000000, fmax_lo_q, 4'h0};
            `RBD_IDX_BURST: rd_mux = {24'h000000, burst_q};
            `RBD_IDX_C_FALL: rd_mux = {24'h000000, c_fall_lead_time_q};
            `RBD_IDX_D_RISE: rd_mux = {24'h000000, d_rise_offset_time_q};
            `RBD_IDX_PERIOD: rd_mux = {{(32-PERIOD_W){1'b0}}, period_q};
            `RBD_IDX_CTRL: rd_mux = {31'h00000000, run_q};
            `RBD_IDX_STATUS: rd_mux = {27'h0000000, PRIMARY_DRIVE_D, PRIMARY_DRIVE_C,
                                       BURST_ACTIVE, SOFT_START, run_q};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // address-phase capture and read data register
    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            wr_pend_q <= 1'b0;
            wr_idx_q <= 8'h00;
            HRDATA <= 32'h00000000;
        end else begin
            wr_pend_q <= addr_ok && HWRITE;
            wr_idx_q <= a_idx;
            if (addr_ok && !HWRITE) begin
                HRDATA <= rd_mux; // stands through the data phase
            end
        end
    end

    // register writes land in the data phase; unmapped writes vanish
    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            fmax_hi_q <= `RBD_RST_BYTE;
            fmax_lo_q <= 4'h0;
            burst_q <= `RBD_RST_BYTE;
            c_fall_lead_time_q <= `RBD_RST_BYTE;
            d_rise_offset_time_q <= `RBD_RST_BYTE;
            period_q <= `RBD_RST_PERIOD;
            run_q <= 1'b0;
        end else if (wr_pend_q) begin
            case (wr_idx_q)
                `RBD_IDX_FMAX_HI: fmax_hi_q <= HWDATA[7:0];
                `RBD_IDX_FMAX_LO: fmax_lo_q <= HWDATA[`RBD_FMAX_LO_MSB:`RBD_FMAX_LO_LSB];
                `RBD_IDX_BURST: burst_q <= HWDATA[7:0];
                `RBD_IDX_C_FALL: c_fall_lead_time_q <= HWDATA[7:0];
                `RBD_IDX_D_RISE: d_rise_offset_time_q <= HWDATA[7:0];
                `RBD_IDX_PERIOD: period_q <= HWDATA[PERIOD_W-1:0];
                `RBD_IDX_CTRL: run_q <= HWDATA[`RBD_CTRL_RUN];
                default: run_q <= run_q; // unmapped: nothing stored
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // cycle timer: advances 5 steps of 5 ns per 25 ns clock
    // integer form first, then cut to the timer width on purpose
    localparam integer STEP_ADV_I = `RBD_STEPS_PER_CLK; // steps per clock, full width
    localparam [PERIOD_W-1:0] STEP_ADV = STEP_ADV_I[PERIOD_W-1:0]; // steps per clock
    wire [PERIOD_W:0] tmr_next = {1'b0, tmr_q} + {1'b0, STEP_ADV}; // no wrap
    // a period below one clock's worth of steps ends a cycle on every clock
    wire cyc_end = run_q && (tmr_next >= {1'b0, period_s_q}); // last clock of the cycle

    always @* begin
        tmr_d = tmr_q;
        if (!run_q || cyc_end) begin
            tmr_d = {PERIOD_W{1'b0}};
        end else begin
            tmr_d = tmr_next[PERIOD_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // burst decision for the next cycle: threshold and enables from the settings in use, period from the register
    wire [PERIOD_W+1:0] burst_thr = {{(PERIOD_W-10){1'b0}}, min_per_s_q}
                                  + {{(PERIOD_W-4){1'b0}}, burst_s_q[`RBD_BURST_OFS_MSB:0]};
    // light load pushes the commanded period below the threshold
    wire burst_want = {2'b00, period_q} < burst_thr;
    // low enable bit gates everything; high bit decides soft start
    wire burst_allow = burst_s_q[`RBD_BURST_EN_LO]
                     && (!SOFT_START || burst_s_q[`RBD_BURST_EN_HI]);

    ////////////////////////////////////////////////////////////////////////////////
    // edge positions, all in 5 ns steps from cycle start
    wire [PERIOD_W-1:0] mid_pt = {1'b0, period_s_q[PERIOD_W-1:1]}; // cycle midpoint
    // c falls lead steps before the end, never before cycle start
    wire [PERIOD_W:0] c_fall_raw = {1'b0, period_s_q} - {{(PERIOD_W-7){1'b0}}, c_lead_s_q};
    wire [PERIOD_W-1:0] c_fall_pt = c_fall_raw[PERIOD_W] ? {PERIOD_W{1'b0}}
                                                         : c_fall_raw[PERIOD_W-1:0];
    // d offset: trailing when top bit clear, leading by 256 minus setting when set
    localparam integer D_SPAN_I = `RBD_D_NEG_SPAN; // wrap of the signed setting, full width
    // cut to the sum width on purpose; the wrap fits any sensible period width
    localparam [PERIOD_W+1:0] D_SPAN = D_SPAN_I[PERIOD_W+1:0]; // wrap of the signed setting
    wire [PERIOD_W+1:0] d_rise_raw = {2'b00, mid_pt} + {{(PERIOD_W-6){1'b0}}, d_ofs_s_q}
                                   - (d_ofs_s_q[7] ? D_SPAN : {(PERIOD_W+2){1'b0}});
    // an early edge that falls before cycle start is held at zero
    wire [PERIOD_W-1:0] d_rise_pt = d_rise_raw[PERIOD_W+1] ? {PERIOD_W{1'b0}}
                                  : (d_rise_raw[PERIOD_W] ? {PERIOD_W{1'b1}} : d_rise_raw[PERIOD_W-1:0]);

    ////////////////////////////////////////////////////////////////////////////////
    // timer, shadow loading and burst skip; a change mid-cycle would cut a pulse short
    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            tmr_q <= {PERIOD_W{1'b0}};
            min_per_s_q <= 12'h000;
            burst_s_q <= `RBD_RST_BYTE;
            c_lead_s_q <= `RBD_RST_BYTE;
            d_ofs_s_q <= `RBD_RST_BYTE;
            period_s_q <= `RBD_RST_PERIOD;
            burst_skip_q <= 1'b0;
        end else begin
            tmr_q <= tmr_d;
            if (!run_q || cyc_end) begin
                // idle or boundary: take the latest settings
                min_per_s_q <= {fmax_hi_q, fmax_lo_q};
                burst_s_q <= burst_q;
                c_lead_s_q <= c_fall_lead_time_q;
                d_ofs_s_q <= d_rise_offset_time_q;
                period_s_q <= period_q;
                burst_skip_q <= run_q && burst_allow && burst_want;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // drive outputs, flopped to keep them glitch free
    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            PRIMARY_DRIVE_C <= 1'b0;
            PRIMARY_DRIVE_D <= 1'b0;
            BURST_ACTIVE <= 1'b0;
            CYCLE_END <= 1'b0;
        end else begin
            // c high from cycle start until its early fall
            PRIMARY_DRIVE_C <= run_q && !burst_skip_q && !cyc_end && (tmr_q < c_fall_pt);
            // d high from its offset rise until the cycle end
            PRIMARY_DRIVE_D <= run_q && !burst_skip_q && !cyc_end && (tmr_q >= d_rise_pt);
            BURST_ACTIVE <= run_q && burst_skip_q;
            CYCLE_END <= cyc_end;
        end
    end

endmodule // rbd_cfg
`default_nettype wire

/* hw/rbd_regs.vh */
// register map, field positions, reset values and timing constants of the burst and edge-timing slice
`ifndef RBD_REGS_VH
`define RBD_REGS_VH

// register indices; byte address is four times the index
`define RBD_IDX_FMAX_HI 8'h46
`define RBD_IDX_FMAX_LO 8'h48
`define RBD_IDX_BURST 8'h4A
`define RBD_IDX_C_FALL 8'h4B
`define RBD_IDX_D_RISE 8'h4D
`define RBD_IDX_PERIOD 8'h60
`define RBD_IDX_CTRL 8'h61
`define RBD_IDX_STATUS 8'h62

// burst control fields
`define RBD_BURST_EN_HI 7
`define RBD_BURST_EN_LO 6
`define RBD_BURST_OFS_MSB 5

// lower frequency-limit register carries its nibble here
`define RBD_FMAX_LO_MSB 7
`define RBD_FMAX_LO_LSB 4

// control and status fields
`define RBD_CTRL_RUN 0
`define RBD_STAT_RUN 0
`define RBD_STAT_SOFT 1
`define RBD_STAT_BURST 2
`define RBD_STAT_C 3
`define RBD_STAT_D 4

// reset values
`define RBD_RST_BYTE 8'h00
`define RBD_RST_PERIOD 16'h00C8

// timing: one edge-timing step and the core clock period, in ns
`define RBD_STEP_NS 5
`define RBD_CLK_NS 25
`define RBD_STEPS_PER_CLK (`RBD_CLK_NS / `RBD_STEP_NS)
`define RBD_D_NEG_SPAN 256

`endif

/* test/rbd_cfg_properties.sv */
// port checker of the burst and drive c/d slice
`timescale 1ns/10ps
`default_nettype none
module rbd_cfg_chk (
    input wire logic REF_CLK, // core clock
    input wire logic RSTN, // reset, active low
    input wire logic HREADYOUT, // slave ready
    input wire logic HRESP, // slave response
    input wire logic PRIMARY_DRIVE_C, // drive c
    input wire logic PRIMARY_DRIVE_D, // drive d
    input wire logic BURST_ACTIVE, // skipped cycle
    input wire logic CYCLE_END // boundary pulse
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);
    ////////////////////////////////////////////////
    // boundary seen now or in the two clocks before
    sequence s_edge; CYCLE_END || $past(CYCLE_END) || $past(CYCLE_END, 2); endsequence
    // one boundary, then a quiet gap; cycles are far longer
    sequence s_gap; CYCLE_END ##1 !CYCLE_END [*8]; endsequence
    property p_okay; HREADYOUT && !HRESP; endproperty
    property p_rst; $rose(RSTN) |-> !PRIMARY_DRIVE_C && !PRIMARY_DRIVE_D && !BURST_ACTIVE; endproperty
    property p_quiet; BURST_ACTIVE && !$past(CYCLE_END) |-> !PRIMARY_DRIVE_C && !PRIMARY_DRIVE_D; endproperty
    property p_c_end; CYCLE_END |-> !PRIMARY_DRIVE_C; endproperty
    property p_d_end; CYCLE_END |-> !PRIMARY_DRIVE_D; endproperty
    property p_d_fall; $fell(PRIMARY_DRIVE_D) |-> CYCLE_END; endproperty
    property p_burst_edge; $changed(BURST_ACTIVE) |-> s_edge; endproperty
    property p_pulse; CYCLE_END |-> s_gap; endproperty
    a_okay: assert property (p_okay) else $error("bus answer not zero-wait okay");
    a_rst: assert property (p_rst) else $error("drive active right after reset");
    a_quiet: assert property (p_quiet) else $error("drive active in skipped cycle");
    a_c_end: assert property (p_c_end) else $error("drive c high at cycle end");
    a_d_end: assert property (p_d_end) else $error("drive d high at cycle end");
    a_d_fall: assert property (p_d_fall) else $error("drive d fell mid-cycle");
    a_burst_edge: assert property (p_burst_edge) else $error("burst changed mid-cycle");
    a_pulse: assert property (p_pulse) else $error("boundary pulse too long");
endmodule // rbd_cfg_chk
bind rbd_cfg rbd_cfg_chk i_chk (.REF_CLK(REF_CLK), .RSTN(RSTN), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .PRIMARY_DRIVE_C(PRIMARY_DRIVE_C), .PRIMARY_DRIVE_D(PRIMARY_DRIVE_D), .BURST_ACTIVE(BURST_ACTIVE),
    .CYCLE_END(CYCLE_END));
`default_nettype wire

/* test/rbd_cfg_tb.sv */
// self-checking bench of the burst and drive c/d slice
`timescale 1ns/10ps
`default_nettype none
`include "rbd_regs.vh"
module rbd_cfg_tb;
    logic clk, rstn, hsel, hwrite, ss; // bench-driven pins
    logic [31:0] haddr, hwdata, rd; // bus values
    logic [1:0] htrans; // transfer type
    wire logic rdy, resp, drv_c, drv_d, burst, cyc; // dut outputs
    wire logic [31:0] hrdata; // read data
    wire logic [7:0] c_at, d_at; // stage log
    int err_total, num_checks, seed_v, lead, ofs;
    logic [7:0] idx_tbl [4] = '{`RBD_IDX_C_FALL, `RBD_IDX_D_RISE, `RBD_IDX_BURST, 8'h70};
    int lead_tbl [4] = '{5, 255, 100, 7};
    int ofs_tbl [4] = '{0, 127, 128, 255};
    rbd_cfg i_dut (.REF_CLK(clk), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(rdy), .HREADYOUT(rdy), .HRESP(resp), .HRDATA(hrdata),
        .SOFT_START(ss), .PRIMARY_DRIVE_C(drv_c), .PRIMARY_DRIVE_D(drv_d), .BURST_ACTIVE(burst), .CYCLE_END(cyc));
    rbd_stage_model i_stage (.clk(clk), .drive_c(drv_c), .drive_d(drv_d), .cyc_end(cyc), .c_fall_at(c_at),
        .d_rise_at(d_at));
    ////////////////////////////////////////////////
    // 40 mhz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // one single ahb transfer; read data lands in rd
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {22'h0, idx, 2'h0};
        do @(posedge clk); while (rdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (rdy !== 1'b1);
        rd = hrdata;
    endtask
    // waits for n boundaries; a hang is cut by the watchdog
    task automatic wait_end(input int n);
        repeat (n) do @(posedge clk); while (cyc !== 1'b1);
    endtask
    // clock after the boundary at which the timer reaches x
    function automatic logic [7:0] pos(input int x);
        return 8'((x + 4) / 5 + 1);
    endfunction
    initial begin
        #(25 * 30000);
        err_total++;
        $display("MISMATCH at %0t: run timed out", $time);
        stop_test;
    end
    initial begin
        {err_total, num_checks, rstn, hsel, hwrite, ss, htrans, haddr, hwdata} = '0;
        seed_v = $urandom(70);
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        bus(0, `RBD_IDX_PERIOD, 0);
        check(rd, 32'h000000C8);
        foreach (idx_tbl[i]) begin
            bus(0, idx_tbl[i], 0);
            check(rd, 32'h0);
            lead = $urandom % 256;
            bus(1, idx_tbl[i], lead);
            bus(0, idx_tbl[i], 0);
            check(rd, (i < 3) ? lead : 0);
        end
        $display("register test done");
        bus(1, `RBD_IDX_PERIOD, 32'd400);
        bus(0, `RBD_IDX_PERIOD, 0);
        check(rd, 32'h00000190);
        bus(1, `RBD_IDX_CTRL, 32'h1);
        for (int i = 0; i < 10; i++) begin
            lead = (i < 4) ? lead_tbl[i] : 5 + $urandom % 251;
            ofs = (i < 4) ? ofs_tbl[i] : $urandom % 256;
            bus(1, `RBD_IDX_C_FALL, lead);
            bus(1, `RBD_IDX_D_RISE, ofs);
            wait_end(3);
            check(c_at, pos(400 - lead));
            check(d_at, pos(ofs < 128 ? 200 + ofs : ofs - 56));
        end
        $display("edge timing test done");
        bus(1, `RBD_IDX_FMAX_HI, 32'h18);
        bus(1, `RBD_IDX_FMAX_LO, 32'hF0);
        bus(0, `RBD_IDX_FMAX_HI, 0);
        check(rd, 32'h00000018);
        bus(0, `RBD_IDX_FMAX_LO, 0);
        check(rd, 32'h000000F0);
        // threshold 399 plus offset 1 or 2 against a period of 400
        for (int i = 0; i < 16; i++) begin
            ss <= i[0];
            bus(1, `RBD_IDX_BURST, {24'h0, i[2:1], 4'h0, i[3], !i[3]});
            wait_end(3);
            repeat (4) @(posedge clk);
            check(burst, i[3] & i[1] & (!i[0] | i[2]));
            bus(0, `RBD_IDX_STATUS, 0);
            check(rd[2:0], {i[3] & i[1] & (!i[0] | i[2]), i[0], 1'b1});
        end
        $display("burst test done");
        stop_test;
    end
endmodule // rbd_cfg_tb
`default_nettype wire

/* test/rbd_stage_model.sv */
// power stage model: logs where each switch turns within a cycle
`timescale 1ns/10ps
`default_nettype none
module rbd_stage_model (
    input wire logic clk, // core clock
    input wire logic drive_c, // gate of switch c
    input wire logic drive_d, // gate of switch d
    input wire logic cyc_end, // cycle boundary pulse
    output logic [7:0] c_fall_at, // clock of c turn-off
    output logic [7:0] d_rise_at // clock of d turn-on
);
    logic [7:0] cnt = 8'h00; // clocks since boundary
    logic c_q = 1'b0; // gate c level one clock ago
    logic d_q = 1'b0; // gate d level one clock ago
    // stage only sees gate edges, so log them against the boundary
    always @(posedge clk) begin
        cnt <= cyc_end ? 8'h01 : cnt + 8'h01;
        if (c_q && !drive_c) c_fall_at <= cnt;
        if (!d_q && drive_d) d_rise_at <= cnt;
        c_q <= drive_c;
        d_q <= drive_d;
    end
endmodule // rbd_stage_model
`default_nettype wire
